// ---- hdl/dppg_defs.vh ----
// constants for the dual parallel port groups block
// assumes a 32-bit AXI4-Lite register bus and byte addresses
`ifndef DPPG_DEFS_VH
`define DPPG_DEFS_VH

// register byte offsets
`define DPPG_G1A_OFS 6'h00
`define DPPG_G1B_OFS 6'h04
`define DPPG_G1C_OFS 6'h08
`define DPPG_CTL1_OFS 6'h0c
`define DPPG_G2A_OFS 6'h10
`define DPPG_G2B_OFS 6'h14
`define DPPG_G2C_OFS 6'h18
`define DPPG_CTL2_OFS 6'h1c
`define DPPG_STAT_OFS 6'h20
`define DPPG_MASK_OFS 6'h24

// group 1 control fields
`define DPPG_C1_MODE_LO 0
`define DPPG_C1_MODE_HI 1
`define DPPG_C1_A_OUT 2
`define DPPG_C1_B_STRB 3
`define DPPG_C1_B_OUT 4
`define DPPG_C1_C_OUT 5
`define DPPG_C1_IRQ_ENABLE_FF_AI 6
`define DPPG_C1_IRQ_ENABLE_FF_AO 7
`define DPPG_C1_IRQ_ENABLE_FF_B 8
`define DPPG_C1_W 9
`define DPPG_C1_RST 9'h000

// port a mode codes
`define DPPG_MODE_BASIC 2'h0
`define DPPG_MODE_STRB 2'h1
`define DPPG_MODE_BIDIR 2'h2

// group 2 control fields
`define DPPG_C2_A_OUT 0
`define DPPG_C2_B_OUT 1
`define DPPG_C2_CLO_OUT 2
`define DPPG_C2_CHI_OUT 3
`define DPPG_C2_W 4
`define DPPG_C2_RST 4'h0

// interrupt status and mask
`define DPPG_ST_A 0
`define DPPG_ST_B 1
`define DPPG_ST_W 2
`define DPPG_ST_RST 2'h0

// dedicated group 1 port c bits
`define DPPG_PC_A_IRQ 3
`define DPPG_PC_A_STB 4
`define DPPG_PC_A_IBF 5
`define DPPG_PC_A_ACK 6
`define DPPG_PC_A_OBF 7
`define DPPG_PC_B_IRQ 0
`define DPPG_PC_B_FLAG 1
`define DPPG_PC_B_HS 2

// bus responses
`define DPPG_RESP_OKAY 2'h0
`define DPPG_RESP_SLVERR 2'h2

`endif

// ---- hdl/dppg_top.v ----
// dual parallel port groups: two three-port groups behind AXI4-Lite
// assumes pins are asynchronous to aclk; drivers outside are inverting
// Overview of operation
// (RULE_01) group 1 port a: basic, strobed, bidirectional
// (RULE_02) bidirectional drive direction follows acknowledge pc6
// (RULE_03) strobed port a interrupt on pc3 raises request
// (RULE_04) basic port a: no interrupt, pc3 is data
// (RULE_05) port a data inverted toward the connector
// (RULE_06) port b basic or strobed only
// (RULE_07) strobed port b interrupt on pc0 raises request
// (RULE_08) basic port b: pc0 data, interrupt inhibited
// (RULE_09) port a handshake bits on pc3 to pc7
// (RULE_10) port b handshake bits on pc0 to pc2
// (RULE_11) port c full 8 bits only when both basic
// (RULE_12) group 2 ports basic only, no interrupts
// (RULE_13) group 2 port c nibbles set independently
// (RULE_14) enabled port interrupts ored onto active-low request
// (RULE_15) static route inputs gate each port interrupt
// (RULE_16) input full set by strobe fall, cleared by read
// (RULE_17) output full set by write, cleared by ack fall
// (RULE_18) output interrupt on ack rise, cleared by write
// (RULE_19) reset clears registers, every port becomes input
`timescale 1ns/1ps
`default_nettype none
`include "dppg_defs.vh"

module dppg_top #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write channels
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // axi4-lite read channels
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // interrupts
  output wire irq,
  output wire board_irq_n,
  input wire irq_route_a,
  input wire irq_route_b,
  // group 1 pins
  input wire [7:0] g1a_in,
  output wire [7:0] g1a_out,
  output wire g1a_oe_n,
  input wire [7:0] g1b_in,
  output wire [7:0] g1b_out,
  output wire g1b_oe_n,
  input wire [7:0] g1c_in,
  output wire [7:0] g1c_out,
  output wire [7:0] g1c_oe_n,
  // group 2 pins
  input wire [7:0] g2a_in,
  output wire [7:0] g2a_out,
  output wire g2a_oe_n,
  input wire [7:0] g2b_in,
  output wire [7:0] g2b_out,
  output wire g2b_oe_n,
  input wire [7:0] g2c_in,
  output wire [7:0] g2c_out,
  output wire [7:0] g2c_oe_n
);

  // word-aligned offset inside the map, else not mapped
  function mapped;
    input [ADDR_W-1:0] a;
    begin
      mapped = (a[ADDR_W-1:6] == 0) && (a[1:0] == 2'h0) &&
               (a[5:0] <= `DPPG_MASK_OFS);
    end
  endfunction

  // two-stage synchroniser for every pin input
  reg [49:0] s1_q;
  reg [49:0] s2_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 50'h0000000ff0000; // port c idles high, no false edge
      s2_q <= 50'h0000000ff0000;
    end else begin
      s1_q <= {irq_route_b, irq_route_a, g2c_in, g2b_in, g2a_in,
               g1c_in, g1b_in, g1a_in};
      s2_q <= s1_q;
    end
  end
  wire [7:0] pa = s2_q[7:0];
  wire [7:0] pb = s2_q[15:8];
  wire [7:0] pc = s2_q[23:16];
  wire [7:0] p2a = s2_q[31:24];
  wire [7:0] p2b = s2_q[39:32];
  wire [7:0] p2c = s2_q[47:40];
  wire route_a = s2_q[48];
  wire route_b = s2_q[49];

  // previous port c level, for handshake edges
  reg [7:0] pc_prev_q;
  always @(posedge aclk) begin
    if (!aresetn)
      pc_prev_q <= 8'hff;
    else
      pc_prev_q <= pc;
  end
  wire [7:0] pc_fall = pc_prev_q & ~pc;
  wire [7:0] pc_rise = ~pc_prev_q & pc;

  // configuration and data latches
  reg [`DPPG_C1_W-1:0] ctl1_q;
  reg [`DPPG_C2_W-1:0] ctl2_q;
  reg [7:0] a_lat_q, b_lat_q, c_lat_q;
  reg [7:0] a_in_q, b_in_q;
  reg [7:0] g2a_lat_q, g2b_lat_q, g2c_lat_q;
  reg [`DPPG_ST_W-1:0] stat_q, mask_q;

  // mode decode; mode code 3 behaves as basic
  wire [1:0] a_mode = ctl1_q[`DPPG_C1_MODE_HI:`DPPG_C1_MODE_LO];
  wire a_m1 = (a_mode == `DPPG_MODE_STRB);
  wire a_m2 = (a_mode == `DPPG_MODE_BIDIR);
  wire a_strb = a_m1 | a_m2;
  wire a_out = ctl1_q[`DPPG_C1_A_OUT];
  wire a_hs_in = (a_m1 & ~a_out) | a_m2;
  wire a_hs_out = (a_m1 & a_out) | a_m2;
  wire b_strb = ctl1_q[`DPPG_C1_B_STRB]; // no bidir code for b
  wire b_out = ctl1_q[`DPPG_C1_B_OUT];

  // write channel state
  reg aw_held_q, w_held_q, awready_q, wready_q, bvalid_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wbit8_q; // ctl1 carries a ninth bit
  reg wstrb0_q;
  reg [1:0] bresp_q;
  wire aw_take = awvalid & awready_q;
  wire w_take = wvalid & wready_q;
  wire do_wr = aw_held_q & w_held_q & ~bvalid_q;
  wire wr_ok = do_wr & wstrb0_q & mapped(awaddr_q);
  wire [5:0] wofs = awaddr_q[5:0];
  wire aw_held_d = (aw_held_q | aw_take) & ~do_wr;
  wire w_held_d = (w_held_q | w_take) & ~do_wr;
  wire bvalid_d = (bvalid_q & ~bready) | do_wr;

  // address and data taken in either order; answer after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `DPPG_RESP_OKAY;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 8'h00;
      wbit8_q <= 1'b0;
      wstrb0_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= ~aw_held_d & ~bvalid_d;
      wready_q <= ~w_held_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (aw_take)
        awaddr_q <= awaddr;
      if (w_take) begin
        wdata_q <= wdata[7:0];
        wbit8_q <= wdata[8];
        wstrb0_q <= wstrb[0];
      end
      if (do_wr)
        bresp_q <= mapped(awaddr_q) ? `DPPG_RESP_OKAY : `DPPG_RESP_SLVERR;
    end
  end

  // read channel; side effects fire when the address is taken
  reg arready_q, rvalid_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_q;
  wire ar_take = arvalid & arready_q;
  wire rd_ok = ar_take & mapped(araddr);
  wire rvalid_d = (rvalid_q & ~rready) | ar_take;

  // one-cycle port access pulses
  wire wr_a = wr_ok & (wofs == `DPPG_G1A_OFS);
  wire wr_b = wr_ok & (wofs == `DPPG_G1B_OFS);
  wire rd_a = rd_ok & (araddr[5:0] == `DPPG_G1A_OFS);
  wire rd_b = rd_ok & (araddr[5:0] == `DPPG_G1B_OFS);

  // port a handshake flags; later statements win, so sets beat clears, except an ack fall beats a write on obf_a_q
  reg ibf_a_q, obf_a_q, int_ai_q, int_ao_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ibf_a_q <= 1'b0;
      obf_a_q <= 1'b0;
      int_ai_q <= 1'b0;
      int_ao_q <= 1'b0;
      a_in_q <= 8'h00;
    end else begin
      if (!a_hs_in) begin
        ibf_a_q <= 1'b0;
        int_ai_q <= 1'b0;
      end
      if (!a_hs_out) begin
        obf_a_q <= 1'b0;
        int_ao_q <= 1'b0;
      end
      if (rd_a) begin
        ibf_a_q <= 1'b0; // RULE_16
        int_ai_q <= 1'b0;
      end
      if (wr_a) begin
        obf_a_q <= a_hs_out; // RULE_17
        int_ao_q <= 1'b0; // RULE_18
      end
      if (a_hs_out && pc_fall[`DPPG_PC_A_ACK])
        obf_a_q <= 1'b0; // RULE_17
      if (a_hs_out && pc_rise[`DPPG_PC_A_ACK] && !obf_a_q &&
          ctl1_q[`DPPG_C1_IRQ_ENABLE_FF_AO])
        int_ao_q <= 1'b1; // RULE_18
      if (a_hs_in && pc_fall[`DPPG_PC_A_STB]) begin
        ibf_a_q <= 1'b1; // RULE_16
        a_in_q <= ~pa; // RULE_05
      end
      if (a_hs_in && pc_rise[`DPPG_PC_A_STB] && ibf_a_q &&
          ctl1_q[`DPPG_C1_IRQ_ENABLE_FF_AI])
        int_ai_q <= 1'b1;
    end
  end
  // RULE_01 RULE_04
  wire port_irq_a = a_strb & (int_ai_q | int_ao_q);

  // port b handshake; direction picks strobe or acknowledge on pc2
  reg ibf_b_q, obf_b_q, int_b_q;
  wire b_hs = b_strb & pc_fall[`DPPG_PC_B_HS];
  wire b_hs_r = b_strb & pc_rise[`DPPG_PC_B_HS];
  always @(posedge aclk) begin
    if (!aresetn) begin
      ibf_b_q <= 1'b0;
      obf_b_q <= 1'b0;
      int_b_q <= 1'b0;
      b_in_q <= 8'h00;
    end else begin
      if (!b_strb || b_out)
        ibf_b_q <= 1'b0;
      if (!b_strb || !b_out)
        obf_b_q <= 1'b0;
      if (!b_strb)
        int_b_q <= 1'b0; // RULE_08
      if (rd_b && !b_out) begin
        ibf_b_q <= 1'b0; // RULE_16
        int_b_q <= 1'b0;
      end
      if (wr_b && b_out) begin
        obf_b_q <= b_strb; // RULE_17
        int_b_q <= 1'b0; // RULE_18
      end
      if (b_hs && b_out)
        obf_b_q <= 1'b0; // RULE_17
      if (b_hs && !b_out) begin
        ibf_b_q <= 1'b1; // RULE_16
        b_in_q <= pb;
      end
      if (b_hs_r && ctl1_q[`DPPG_C1_IRQ_ENABLE_FF_B] &&
          (b_out ? !obf_b_q : ibf_b_q))
        int_b_q <= 1'b1; // RULE_18
    end
  end
  wire port_irq_b = b_strb & int_b_q; // RULE_06

  // register writes; reset leaves every port an input
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctl1_q <= `DPPG_C1_RST; // RULE_19
      ctl2_q <= `DPPG_C2_RST;
      mask_q <= `DPPG_ST_RST;
      a_lat_q <= 8'h00;
      b_lat_q <= 8'h00;
      c_lat_q <= 8'h00;
      g2a_lat_q <= 8'h00;
      g2b_lat_q <= 8'h00;
      g2c_lat_q <= 8'h00;
    end else if (wr_ok) begin
      case (wofs)
        `DPPG_G1A_OFS: a_lat_q <= wdata_q;
        `DPPG_G1B_OFS: b_lat_q <= wdata_q;
        `DPPG_G1C_OFS: c_lat_q <= wdata_q;
        `DPPG_CTL1_OFS: ctl1_q <= {wbit8_q, wdata_q}; // irq_enable_ff b in bit 8
        `DPPG_G2A_OFS: g2a_lat_q <= wdata_q;
        `DPPG_G2B_OFS: g2b_lat_q <= wdata_q;
        `DPPG_G2C_OFS: g2c_lat_q <= wdata_q;
        `DPPG_CTL2_OFS: ctl2_q <= wdata_q[`DPPG_C2_W-1:0];
        `DPPG_MASK_OFS: mask_q <= wdata_q[`DPPG_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // group 1 port c drive: dedicated bits override the data latch
  reg [7:0] c_o, c_oe_n;
  always @* begin
    c_o = c_lat_q;
    c_oe_n = {8{~ctl1_q[`DPPG_C1_C_OUT]}}; // RULE_11
    if (a_strb) begin
      c_o[`DPPG_PC_A_IRQ] = port_irq_a; // RULE_03 RULE_09
      c_o[`DPPG_PC_A_IBF] = ibf_a_q;
      c_o[`DPPG_PC_A_OBF] = ~obf_a_q;
      c_oe_n[7:3] = 5'h0a; // strobe and ack are inputs
    end
    if (b_strb) begin
      c_o[`DPPG_PC_B_IRQ] = port_irq_b; // RULE_07 RULE_10
      c_o[`DPPG_PC_B_FLAG] = b_out ? ~obf_b_q : ibf_b_q;
      c_oe_n[2:0] = 3'h4;
    end
  end

  // pin drivers, all registered
  reg [7:0] g1a_out_q, g1b_out_q, g1c_out_q, g1c_oe_n_q;
  reg g1a_oe_n_q, g1b_oe_n_q, g2a_oe_n_q, g2b_oe_n_q;
  reg [7:0] g2c_oe_n_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      g1a_out_q <= 8'hff;
      g1b_out_q <= 8'h00;
      g1c_out_q <= 8'h00;
      g1a_oe_n_q <= 1'b1; // RULE_19
      g1b_oe_n_q <= 1'b1;
      g1c_oe_n_q <= 8'hff;
      g2a_oe_n_q <= 1'b1;
      g2b_oe_n_q <= 1'b1;
      g2c_oe_n_q <= 8'hff;
    end else begin
      g1a_out_q <= ~a_lat_q; // RULE_05
      if (a_m2)
        g1a_oe_n_q <= pc[`DPPG_PC_A_ACK]; // RULE_02
      else
        g1a_oe_n_q <= ~a_out;
      g1b_out_q <= b_lat_q;
      g1b_oe_n_q <= ~b_out;
      g1c_out_q <= c_o;
      g1c_oe_n_q <= c_oe_n;
      // RULE_12 RULE_13
      g2a_oe_n_q <= ~ctl2_q[`DPPG_C2_A_OUT];
      g2b_oe_n_q <= ~ctl2_q[`DPPG_C2_B_OUT];
      g2c_oe_n_q <= {{4{~ctl2_q[`DPPG_C2_CHI_OUT]}},
                     {4{~ctl2_q[`DPPG_C2_CLO_OUT]}}};
    end
  end

  // interrupt status: sticky, write one to clear, set wins
  reg [1:0] pend_prev_q;
  wire [1:0] ev = {port_irq_b, port_irq_a} & ~pend_prev_q;
  reg irq_q, board_irq_n_q;
  wire [1:0] st_clr = (wr_ok && wofs == `DPPG_STAT_OFS) ?
                      wdata_q[1:0] : 2'h0;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_prev_q <= 2'h0;
      stat_q <= `DPPG_ST_RST;
      irq_q <= 1'b0;
      board_irq_n_q <= 1'b1;
    end else begin
      pend_prev_q <= {port_irq_b, port_irq_a};
      stat_q <= (stat_q & ~st_clr) | ev;
      irq_q <= |(stat_q & mask_q);
      board_irq_n_q <= ~((port_irq_a & route_a) |
                         (port_irq_b & route_b)); // RULE_14 RULE_15
    end
  end

  // read data mux
  reg [7:0] rd_v;
  always @* begin
    case (araddr[5:0])
      `DPPG_G1A_OFS: rd_v = a_strb ? a_in_q : (a_out ? a_lat_q : ~pa);
      `DPPG_G1B_OFS: rd_v = b_out ? b_lat_q : (b_strb ? b_in_q : pb);
      `DPPG_G1C_OFS: rd_v = (g1c_out_q & ~g1c_oe_n_q) | (pc & g1c_oe_n_q);
      `DPPG_CTL1_OFS: rd_v = ctl1_q[7:0];
      `DPPG_G2A_OFS: rd_v = g2a_oe_n_q ? p2a : g2a_lat_q;
      `DPPG_G2B_OFS: rd_v = g2b_oe_n_q ? p2b : g2b_lat_q;
      `DPPG_G2C_OFS: rd_v = (g2c_lat_q & ~g2c_oe_n_q) | (p2c & g2c_oe_n_q);
      `DPPG_CTL2_OFS: rd_v = {4'h0, ctl2_q};
      `DPPG_STAT_OFS: rd_v = {6'h00, stat_q};
      `DPPG_MASK_OFS: rd_v = {6'h00, mask_q};
      default: rd_v = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `DPPG_RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rresp_q <= rd_ok ? `DPPG_RESP_OKAY : `DPPG_RESP_SLVERR;
        rdata_q <= rd_ok ? {23'h0, ctl1_q[8] &
                            (araddr[5:0] == `DPPG_CTL1_OFS), rd_v} : 32'h0;
      end
    end
  end

  // outputs straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign irq = irq_q;
  assign board_irq_n = board_irq_n_q;
  assign g1a_out = g1a_out_q;
  assign g1a_oe_n = g1a_oe_n_q;
  assign g1b_out = g1b_out_q;
  assign g1b_oe_n = g1b_oe_n_q;
  assign g1c_out = g1c_out_q;
  assign g1c_oe_n = g1c_oe_n_q;
  assign g2a_out = g2a_lat_q;
  assign g2a_oe_n = g2a_oe_n_q;
  assign g2b_out = g2b_lat_q;
  assign g2b_oe_n = g2b_oe_n_q;
  assign g2c_out = g2c_lat_q;
  assign g2c_oe_n = g2c_oe_n_q;

endmodule

`default_nettype wire

// ---- dv/dppg_properties.sv ----
// bus and interrupt checker for the parallel port groups top
// assumes a bind onto dppg_top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "dppg_defs.vh"
module dppg_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // interrupts and pins
  input wire logic irq,
  input wire logic board_irq_n,
  input wire logic g1a_oe_n,
  input wire logic [7:0] g1c_out,
  input wire logic [7:0] g1c_oe_n,
  input wire logic [7:0] g2c_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write channels taken in one edge
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  // reset check may not be disabled by the reset it watches
  a_reset_inputs: assert property (disable iff (1'b0)
    !aresetn |=> g1a_oe_n && (&g1c_oe_n) && (&g2c_oe_n)
      && !irq && board_irq_n)
    else $error("ports not inputs after reset");
  // both halves are held one edge, the answer rises on the next
  a_write_answer: assert property (s_wr_take |=> ##1 bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |=> rvalid)
    else $error("read response late");
  a_bresp_holds: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_rbusy_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_err_zero: assert property (rvalid && rresp == `DPPG_RESP_SLVERR
    |-> rdata == 32'h0)
    else $error("error read returned data");
  // request low only while a port interrupt pin shows it, one cycle slack
  a_board_source: assert property (!board_irq_n
    |-> g1c_out[3] || g1c_out[0] || $past(g1c_out[3]) || $past(g1c_out[0]))
    else $error("board request without source");
endmodule
bind dppg_top dppg_props u_props (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .irq, .board_irq_n, .g1a_oe_n, .g1c_out, .g1c_oe_n,
  .g2c_oe_n);
`default_nettype wire

// ---- dv/dppg_periph.sv ----
// far-side peripheral: connector levels and handshake pulses
// assumes the bench resolves pins the device drives itself
`timescale 1ns/1ps
`default_nettype none
module dppg_periph (
  // clock
  input wire logic aclk,
  // connector levels offered
  output logic [7:0] pa,
  output logic [7:0] pb,
  output logic [7:0] pc
);
  // handshake lines idle high
  initial begin
    pa = 8'h00;
    pb = 8'h00;
    pc = 8'hff;
  end
  // port a connector is negative true
  task put_a(input logic [7:0] d);
    pa <= ~d;
  endtask
  task level(input int b, input logic v);
    pc[b] <= v;
  endtask
  // low pulse held past the pin synchroniser, then a quiet gap
  task pulse(input int b);
    begin
      @(posedge aclk);
      pc[b] <= 1'b0;
      repeat (5) @(posedge aclk);
      pc[b] <= 1'b1;
      repeat (5) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/dppg_top_tb.sv ----
// self-checking bench for the parallel port groups top
// assumes dppg_defs.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "dppg_defs.vh"
module dppg_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic irq_route_a = 1'b1, irq_route_b = 1'b1;
  logic [7:0] g2a_in = 8'h00, g2b_in = 8'h00, g2c_in = 8'h00;
  wire logic awready, wready, bvalid, arready, rvalid, irq, board_irq_n;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic g1a_oe_n, g1b_oe_n, g2a_oe_n, g2b_oe_n;
  wire logic [7:0] g1a_in, g1a_out, g1b_in, g1b_out, g1c_in, g1c_out;
  wire logic [7:0] g1c_oe_n, g2a_out, g2b_out, g2c_out, g2c_oe_n, pa, pb, pc;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  integer seed;
  logic [7:0] d, v;
  logic [31:0] rv;
  logic [1:0] resp;

  always #20 aclk = ~aclk;
  // a pin the device drives reads back its own level
  assign g1a_in = g1a_oe_n ? pa : g1a_out;
  assign g1b_in = g1b_oe_n ? pb : g1b_out;
  assign g1c_in = (g1c_oe_n & pc) | (~g1c_oe_n & g1c_out);

  dppg_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .irq, .board_irq_n, .irq_route_a,
    .irq_route_b, .g1a_in, .g1a_out, .g1a_oe_n, .g1b_in, .g1b_out, .g1b_oe_n,
    .g1c_in, .g1c_out, .g1c_oe_n, .g2a_in, .g2a_out, .g2a_oe_n, .g2b_in,
    .g2b_out, .g2b_oe_n, .g2c_in, .g2c_out, .g2c_oe_n);
  dppg_periph per (.aclk, .pa, .pb, .pc);

  // nibble drive enables expected from a group 2 control code
  function logic [7:0] g2c_exp(input logic [3:0] k);
    g2c_exp = {{4{~k[3]}}, {4{~k[2]}}};
  endfunction

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    begin
      checks++;
      if (s !== e) begin
        err_total++;
        $display("BAD %s exp %h seen %h", n, e, s);
      end
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] x);
    int n;
    logic ad, wd, bd;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= x;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 0;
      wd = 0;
      bd = 0;
      for (n = 0; n < 100 && !bd; n++) begin
        @(posedge aclk);
        if (!ad && awready) begin
          ad = 1;
          awvalid <= 1'b0;
        end
        if (!wd && wready) begin
          wd = 1;
          wvalid <= 1'b0;
        end
        if (bvalid) begin
          bd = 1;
          resp = bresp;
          bready <= 1'b0;
        end
      end
      if (!bd) err_total++;
    end
  endtask

  task rd(input logic [7:0] a);
    int n;
    logic ad, rdn;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ad = 0;
      rdn = 0;
      for (n = 0; n < 100 && !rdn; n++) begin
        @(posedge aclk);
        if (!ad && arready) begin
          ad = 1;
          arvalid <= 1'b0;
        end
        if (rvalid) begin
          rdn = 1;
          rv = rdata;
          resp = rresp;
          rready <= 1'b0;
        end
      end
      if (!rdn) err_total++;
    end
  endtask

  task conclude;
    begin
      if (err_total == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // hang guard, far above the scripted run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    seed = 32'hf7cc;
    tick(12);
    chk("oe_all", {g1a_oe_n, g1b_oe_n, g2a_oe_n, g2b_oe_n, g1c_oe_n, g2c_oe_n},
      20'hfffff);
    chk("irqs", {irq, board_irq_n, g1a_out}, 10'h1ff);
    aresetn <= 1'b1;
    rd(`DPPG_CTL1_OFS);
    chk("ctl1_rst", rv, 32'h0);
    rd(8'h3c);
    chk("unmapped", rv, 32'h0);
    chk("rd_err", resp, `DPPG_RESP_SLVERR);
    wr(8'h3c, 32'h0ff);
    chk("wr_err", resp, `DPPG_RESP_SLVERR);
    // basic port a both ways through the inverting connector
    d = 8'($random(seed));
    wr(`DPPG_CTL1_OFS, 32'h004);
    chk("wr_ok", resp, `DPPG_RESP_OKAY);
    wr(`DPPG_G1A_OFS, {24'h0, d});
    tick(2);
    chk("g1a_out", {g1a_oe_n, g1a_out}, {1'b0, 8'(~d)});
    wr(`DPPG_CTL1_OFS, 32'h000);
    d = 8'($random(seed));
    per.put_a(d);
    tick(4);
    rd(`DPPG_G1A_OFS);
    chk("g1a_in", rv, {24'h0, d});
    // basic port c: irq bits are plain data, no request
    v = 8'($random(seed)) | 8'h09;
    wr(`DPPG_CTL1_OFS, 32'h020);
    wr(`DPPG_G1C_OFS, {24'h0, v});
    tick(4);
    chk("g1c_data", {g1c_oe_n, g1c_out}, {8'h00, v});
    chk("no_req", board_irq_n, 1'b1);
    // strobed input on port a, masked then unmasked
    wr(`DPPG_CTL1_OFS, 32'h041);
    wr(`DPPG_MASK_OFS, 32'h0);
    d = 8'($random(seed));
    per.put_a(d);
    per.pulse(`DPPG_PC_A_STB);
    chk("ibf_a", g1c_out[5], 1'b1);
    chk("irq_a", g1c_out[3], 1'b1);
    chk("board_a", board_irq_n, 1'b0);
    chk("masked", irq, 1'b0);
    wr(`DPPG_MASK_OFS, 32'h3);
    tick(2);
    chk("unmasked", irq, 1'b1);
    irq_route_a <= 1'b0;
    tick(5);
    chk("route_a", board_irq_n, 1'b1);
    irq_route_a <= 1'b1;
    rd(`DPPG_G1A_OFS);
    chk("latch_a", rv, {24'h0, d});
    tick(2);
    chk("ibf_clr", {g1c_out[5], g1c_out[3]}, 2'b00);
    wr(`DPPG_STAT_OFS, 32'h1);
    rd(`DPPG_STAT_OFS);
    chk("w1c", {irq, rv[7:0]}, 9'h0);
    // strobed output on port b, interrupt after acknowledge
    wr(`DPPG_CTL1_OFS, 32'h118);
    d = 8'($random(seed));
    wr(`DPPG_G1B_OFS, {24'h0, d});
    tick(2);
    chk("g1b_out", {g1b_oe_n, g1b_out}, {1'b0, d});
    chk("obf_b", g1c_out[1], 1'b0);
    per.pulse(`DPPG_PC_B_HS);
    tick(2);
    chk("obf_clr", g1c_out[1], 1'b1);
    chk("irq_b", {g1c_out[0], board_irq_n, irq}, 3'b101);
    wr(`DPPG_G1B_OFS, {24'h0, d});
    tick(2);
    chk("irq_b_clr", g1c_out[0], 1'b0);
    // strobed output on port a, interrupt after acknowledge
    wr(`DPPG_CTL1_OFS, 32'h085);
    d = 8'($random(seed));
    wr(`DPPG_G1A_OFS, {24'h0, d});
    tick(2);
    chk("obf_a", {g1c_out[7], g1a_oe_n, g1a_out}, {2'b00, 8'(~d)});
    per.pulse(`DPPG_PC_A_ACK);
    chk("ack_a", {g1c_out[7], g1c_out[3]}, 2'b11);
    wr(`DPPG_G1A_OFS, {24'h0, d});
    tick(2);
    chk("ack_a_clr", g1c_out[3], 1'b0);
    // bidirectional: drive only while acknowledge is low
    wr(`DPPG_CTL1_OFS, 32'h002);
    per.level(`DPPG_PC_A_ACK, 1'b0);
    tick(5);
    chk("bidir_drv", g1a_oe_n, 1'b0);
    per.level(`DPPG_PC_A_ACK, 1'b1);
    tick(5);
    chk("bidir_off", g1a_oe_n, 1'b1);
    // every group 2 direction code
    for (int i = 0; i < 16; i++) begin
      wr(`DPPG_CTL2_OFS, i);
      tick(1);
      chk("g2c_oe", g2c_oe_n, g2c_exp(4'(i)));
      chk("g2ab_oe", {g2a_oe_n, g2b_oe_n}, {~i[0], ~i[1]});
    end
    v = 8'($random(seed));
    wr(`DPPG_G2C_OFS, {24'h0, v});
    tick(1);
    chk("g2c_out", g2c_out, v);
    wr(`DPPG_G2A_OFS, {24'h0, ~v});
    wr(`DPPG_G2B_OFS, {24'h0, v ^ 8'h5a});
    tick(1);
    chk("g2ab_out", {g2a_out, g2b_out}, {~v, v ^ 8'h5a});
    wr(`DPPG_CTL2_OFS, 32'h0);
    g2a_in <= ~v;
    g2b_in <= v;
    g2c_in <= v ^ 8'h0f;
    tick(4);
    rd(`DPPG_G2B_OFS);
    chk("g2b_in", rv, {24'h0, v});
    rd(`DPPG_G2A_OFS);
    chk("g2a_in", rv, {24'h0, ~v});
    rd(`DPPG_G2C_OFS);
    chk("g2c_in", rv, {24'h0, v ^ 8'h0f});
    conclude();
  end
endmodule
`default_nettype wire
